// ### bbm_map.svh
`ifndef BBM_MAP_SVH
`define BBM_MAP_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define BBM_OP_DIR_RN_HI   5'h11
`define BBM_OP_DIR_DIR     8'h85
`define BBM_OP_DIR_IMM     8'h75
`define BBM_OP_C_BIT       8'hA2
`define BBM_OP_BIT_C       8'h92

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BBM_CLKS_PER_MCYC  4'hC
`define BBM_MCYC_LONG      2'h2
`define BBM_MCYC_SHORT     2'h1

`endif

// ### bbm_pkg.sv
`default_nettype none
package bbm_pkg;
    typedef enum logic [2:0] {
        BBM_IDLE,
        BBM_DEC,
        BBM_OP1,
        BBM_OP2,
        BBM_READ,
        BBM_WAIT,
        BBM_HOLD,
        BBM_WB
    } bbm_state_t;
endpackage : bbm_pkg
`default_nettype wire

// ### bbm_byte_reg.sv
`default_nettype none
module bbm_byte_reg #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Load port
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] val_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            val_q <= '0;
        end else if (i_load) begin
            val_q <= i_d;
        end
    end

    assign o_q = val_q;
endmodule // bbm_byte_reg
`default_nettype wire

// ### bbm_move_decode.sv
`include "bbm_map.svh"
`default_nettype none
module bbm_move_decode (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Instruction byte stream
    input  wire logic       i_fetch_valid,
    input  wire logic [7:0] i_fetch_byte,
    output logic            o_fetch_ready,
    // Core state
    input  wire logic [1:0] i_bank_sel,
    input  wire logic       i_carry,
    output logic            o_carry_wr,
    output logic            o_carry_wdata,
    // Internal data memory
    output logic            o_mem_rd,
    output logic            o_mem_wr,
    output logic      [7:0] o_mem_addr,
    output logic      [7:0] o_mem_wdata,
    input  wire logic [7:0] i_mem_rdata,
    // Bit space
    output logic            o_bit_rd,
    output logic            o_bit_wr,
    output logic      [7:0] o_bit_addr,
    output logic            o_bit_wdata,
    input  wire logic       i_bit_rdata,
    // Status
    output logic            o_done,
    output logic            o_illegal
);
    import bbm_pkg::*;

    bbm_state_t state_q;
    bbm_state_t state_d;
    logic [7:0] op_q;
    logic [7:0] op1_q;
    logic [7:0] op2_q;
    logic [7:0] data_q;
    logic [1:0] bank_q;
    logic [3:0] div_q;
    logic [1:0] mcyc_q;
    logic [5:0] elapsed_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire accept    = i_fetch_valid && o_fetch_ready;
    wire is_dir_rn = (op_q[7:3] == `BBM_OP_DIR_RN_HI);
    wire is_dir_dir = (op_q == `BBM_OP_DIR_DIR);
    wire is_dir_imm = (op_q == `BBM_OP_DIR_IMM);
    wire is_c_bit  = (op_q == `BBM_OP_C_BIT);
    wire is_bit_c  = (op_q == `BBM_OP_BIT_C);
    wire is_bit    = is_c_bit || is_bit_c;
    wire legal     = is_dir_rn || is_dir_dir || is_dir_imm || is_bit;
    wire two_opnd  = is_dir_dir || is_dir_imm;
    wire needs_rd  = is_dir_rn || is_dir_dir || is_c_bit;
    wire [7:0] bank_addr = {3'h0, bank_q, op_q[2:0]};
    wire [1:0] need_mcyc =
        is_c_bit ? `BBM_MCYC_SHORT : `BBM_MCYC_LONG;
    wire mcyc_tick = (div_q == (`BBM_CLKS_PER_MCYC - 4'h1));
    wire time_ok   = (mcyc_q >= need_mcyc);
    wire [7:0] src_addr = is_dir_rn ? bank_addr : op1_q;
    // Byte destination: second operand only for direct to direct
    wire [7:0] dst_addr = is_dir_dir ? op2_q : op1_q;
    wire [7:0] wdata    = is_dir_imm ? op2_q : data_q;
    // The bit read leaves OP1 while op1_q is still loading
    wire [7:0] bit_addr = (state_q == BBM_OP1) ? i_fetch_byte : op1_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            BBM_IDLE: if (accept) state_d = BBM_DEC;
            BBM_DEC:  state_d = legal ? BBM_OP1 : BBM_IDLE;
            BBM_OP1: begin
                if (accept) begin
                    if (two_opnd) state_d = BBM_OP2;
                    else if (needs_rd) state_d = BBM_READ;
                    else state_d = BBM_HOLD;
                end
            end
            BBM_OP2: begin
                if (accept) state_d = is_dir_dir ? BBM_READ : BBM_HOLD;
            end
            BBM_READ: state_d = BBM_WAIT;
            BBM_WAIT: state_d = BBM_HOLD;
            BBM_HOLD: if (time_ok) state_d = BBM_WB;
            BBM_WB:   state_d = BBM_IDLE;
            default:  state_d = BBM_IDLE;
        endcase
    end

    wire fetch_st  = (state_d == BBM_IDLE) || (state_d == BBM_OP1) ||
                     (state_d == BBM_OP2);
    wire enter_rd  = (state_d == BBM_READ) && (state_q != BBM_READ);
    wire enter_wb  = (state_d == BBM_WB) && (state_q != BBM_WB);

    bbm_byte_reg #(.W(8)) u_op (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_load (accept && (state_q == BBM_IDLE)),
        .i_d    (i_fetch_byte),
        .o_q    (op_q)
    );

    bbm_byte_reg #(.W(8)) u_op1 (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_load (accept && (state_q == BBM_OP1)),
        .i_d    (i_fetch_byte),
        .o_q    (op1_q)
    );

    bbm_byte_reg #(.W(8)) u_op2 (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_load (accept && (state_q == BBM_OP2)),
        .i_d    (i_fetch_byte),
        .o_q    (op2_q)
    );

    // Source is only sampled, never written back
    bbm_byte_reg #(.W(8)) u_data (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_load (state_q == BBM_WAIT),
        .i_d    (is_c_bit ? {7'h00, i_bit_rdata} : i_mem_rdata),
        .o_q    (data_q)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= BBM_IDLE;
            bank_q  <= 2'h0;
        end else begin
            state_q <= state_d;
            if (accept && (state_q == BBM_IDLE)) begin
                bank_q <= i_bank_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // Machine cycle timing
    // ------------------------------------------------------------
    // Divider restarts at opcode so the count is exact per instruction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q     <= 4'h0;
            mcyc_q    <= 2'h0;
            elapsed_q <= 6'h00;
        end else if (accept && (state_q == BBM_IDLE)) begin
            div_q     <= 4'h0;
            mcyc_q    <= 2'h0;
            elapsed_q <= 6'h01;
        end else begin
            div_q <= mcyc_tick ? 4'h0 : div_q + 4'h1;
            if (mcyc_tick && (mcyc_q != 2'h3)) begin
                mcyc_q <= mcyc_q + 2'h1;
            end
            if (elapsed_q != 6'h3F) begin
                elapsed_q <= elapsed_q + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fetch_ready <= 1'b0;
            o_mem_rd      <= 1'b0;
            o_mem_wr      <= 1'b0;
            o_mem_addr    <= 8'h00;
            o_mem_wdata   <= 8'h00;
            o_bit_rd      <= 1'b0;
            o_bit_wr      <= 1'b0;
            o_bit_addr    <= 8'h00;
            o_bit_wdata   <= 1'b0;
            o_carry_wr    <= 1'b0;
            o_carry_wdata <= 1'b0;
            o_done        <= 1'b0;
            o_illegal     <= 1'b0;
        end else begin
            o_fetch_ready <= fetch_st;
            o_mem_rd      <= enter_rd && !is_bit;
            o_bit_rd      <= enter_rd && is_c_bit;
            // Only one destination strobe per move
            o_mem_wr      <= enter_wb && !is_bit;
            o_bit_wr      <= enter_wb && is_bit_c;
            o_carry_wr    <= enter_wb && is_c_bit;
            o_done        <= enter_wb;
            o_illegal     <= (state_q == BBM_DEC) && !legal;
            if (enter_rd) begin
                o_mem_addr <= src_addr;
                o_bit_addr <= bit_addr;
            end else if (enter_wb) begin
                o_mem_addr <= dst_addr;
                o_bit_addr <= op1_q;
            end
            if (enter_wb) begin
                o_mem_wdata   <= wdata;
                o_bit_wdata   <= i_carry;
                o_carry_wdata <= data_q[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bank_src_addr: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_mem_rd && is_dir_rn) |->
            (o_mem_addr == {3'h0, bank_q, op_q[2:0]}))
        else $error("bank register source address wrong");

    a_bank_capture: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (accept && (state_q == BBM_IDLE)) |=> (bank_q == $past(i_bank_sel)))
        else $error("bank select not held for instruction");

    // Window closes before a following move can reach its own write
    a_dir_dir_write: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_mem_rd && is_dir_dir) ##1 1'b1 ##[1:21] o_mem_wr |->
            (o_mem_addr == op2_q) && (o_mem_wdata == data_q))
        else $error("direct move wrote wrong place or value");

    a_imm_write: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_mem_wr && is_dir_imm) |->
            (o_mem_addr == op1_q) && (o_mem_wdata == op2_q) && !o_mem_rd)
        else $error("immediate move wrote wrong place or value");

    a_two_mcyc_time: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_done && !is_c_bit) |-> (elapsed_q >= 6'h1A))
        else $error("two cycle move finished early");

    a_bit_copy_val: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        o_bit_wr |-> (o_bit_wdata == $past(i_carry)) && !o_bit_rd)
        else $error("bit destination not given carry value");

    a_carry_pairing: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_bit_wr || o_carry_wr || o_bit_rd) |-> is_bit)
        else $error("bit access outside a carry bit move");

    a_single_dest: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_bit_wr || o_carry_wr) |->
            !o_mem_wr && !(o_bit_wr && o_carry_wr) ##1 !o_bit_wr)
        else $error("bit move touched a second location");
endmodule // bbm_move_decode
`default_nettype wire

// ### bbm_fetch_model.sv
`default_nettype none
module bbm_fetch_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Byte stream
    input  wire logic       i_ready,
    output logic            o_valid,
    output logic      [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] q_q[$];

    function automatic void push(input logic [7:0] b);
        q_q.push_back(b);
    endfunction

    // A byte stays put until taken; with nothing queued the lines
    // toggle so a stale byte is never mistaken for a fresh one
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_byte  <= 8'hFF;
        end else begin
            if (o_valid && i_ready) void'(q_q.pop_front());
            o_valid <= q_q.size() != 0;
            o_byte  <= (q_q.size() != 0) ? q_q[0] : ~o_byte;
        end
    end
endmodule // bbm_fetch_model
`default_nettype wire

// ### bbm_testbench.sv
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       i_clk, i_rst_n, i_fetch_valid, o_fetch_ready, i_carry;
    logic [7:0] i_fetch_byte, o_mem_addr, o_mem_wdata, i_mem_rdata;
    logic [7:0] o_bit_addr;
    logic [1:0] i_bank_sel;
    logic       o_carry_wr, o_carry_wdata, o_mem_rd, o_mem_wr, o_bit_rd;
    logic       o_bit_wr, o_bit_wdata, i_bit_rdata, o_done, o_illegal;
    int         fails, n_checks, cyc, t_op, lat;
    int         cnt[5];
    bit         expect_op;

    bbm_move_decode bbm_move_decode_i (.i_clk, .i_rst_n, .i_fetch_valid,
        .i_fetch_byte, .o_fetch_ready, .i_bank_sel, .i_carry, .o_carry_wr,
        .o_carry_wdata, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata,
        .i_mem_rdata, .o_bit_rd, .o_bit_wr, .o_bit_addr, .o_bit_wdata,
        .i_bit_rdata, .o_done, .o_illegal);
    bbm_fetch_model bbm_fetch_model_i (.i_clk, .i_rst_n,
        .i_ready(o_fetch_ready), .o_valid(i_fetch_valid),
        .o_byte(i_fetch_byte));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // -----------------------------------------------------------------
    // Memory and bit space: answer one cycle after the strobe, toggle
    // otherwise so a late sample cannot pass by luck
    // -----------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        i_mem_rdata <= o_mem_rd ? (o_mem_addr ^ 8'h5A) : ~i_mem_rdata;
        i_bit_rdata <= o_bit_rd ? ^o_bit_addr : ~i_bit_rdata;
        if (expect_op && i_fetch_valid && o_fetch_ready) begin
            t_op = cyc;
            expect_op = 1'b0;
        end
    end

    task automatic print_verdict();
        $display("Checks: %0d, mismatches: %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic run(input logic [7:0] op, a, b, input int nb,
                       input logic [1:0] bk, input logic c);
        int i;
        @(posedge i_clk);
        i_bank_sel <= bk;
        i_carry <= c;
        #1;
        cnt = '{default: 0};
        expect_op = 1'b1;
        bbm_fetch_model_i.push(op);
        if (nb > 1) bbm_fetch_model_i.push(a);
        if (nb > 2) bbm_fetch_model_i.push(b);
        for (i = 0; i < 60; i++) begin
            @(posedge i_clk);
            #1;
            cnt[0] += int'(o_mem_rd);
            cnt[1] += int'(o_mem_wr);
            cnt[2] += int'(o_bit_rd);
            cnt[3] += int'(o_bit_wr);
            cnt[4] += int'(o_carry_wr);
            if (o_done === 1'b1 || o_illegal === 1'b1) break;
        end
        lat = cyc - 1 - t_op;
        if (i == 60) begin
            fails++;
            print_verdict();
        end
    endtask

    task automatic t_reg_to_dir();
        for (int r = 0; r < 8; r++) begin
            run(8'h88 | r[7:0], 8'h30 + r[7:0], 8'h00, 2, r[1:0], 1'b0);
            `CHK(lat, 25)
            `CHK(o_mem_wdata, {3'h0, r[1:0], r[2:0]} ^ 8'h5A)
            `CHK(o_mem_addr, 8'h30 + r[7:0])
            `CHK(o_mem_wr, 1'b1)
            `CHK(cnt[0], 1)
        end
    endtask

    task automatic t_dir_to_dir();
        run(8'h85, 8'h41, 8'h62, 3, 2'h2, 1'b0);
        `CHK(lat, 25)
        `CHK(o_mem_addr, 8'h62)
        `CHK(o_mem_wdata, 8'h41 ^ 8'h5A)
        `CHK(cnt[0], 1)
    endtask

    // Unhandled forms must take no operands and write nothing
    task automatic t_illegal();
        logic [7:0] ops[5] = '{8'hE8, 8'hF5, 8'hA6, 8'h76, 8'hF6};
        foreach (ops[k]) begin
            run(ops[k], 8'h00, 8'h00, 1, 2'h0, 1'b0);
            `CHK(o_illegal, 1'b1)
            `CHK(cnt[1] + cnt[3] + cnt[4], 0)
        end
    endtask

    task automatic t_imm();
        run(8'h75, 8'h23, 8'hC4, 3, 2'h3, 1'b1);
        `CHK(lat, 25)
        `CHK(o_mem_addr, 8'h23)
        `CHK(o_mem_wdata, 8'hC4)
        `CHK(cnt[0], 0)
    endtask

    task automatic t_bit_moves();
        logic [7:0] ba;
        for (int c = 0; c < 2; c++) begin
            run(8'h92, 8'h9B, 8'h00, 2, 2'h1, c[0]);
            `CHK(lat, 25)
            `CHK(o_bit_addr, 8'h9B)
            `CHK(o_bit_wdata, c[0])
            `CHK(cnt[3], 1)
            `CHK(cnt[1] + cnt[2] + cnt[4], 0)
            ba = c[0] ? 8'h17 : 8'h16;
            run(8'hA2, ba, 8'h00, 2, 2'h0, c[0]);
            `CHK(lat, 13)
            `CHK(o_carry_wr, 1'b1)
            `CHK(o_carry_wdata, ^ba)
            `CHK(cnt[1] + cnt[3], 0)
            `CHK(cnt[2], 1)
        end
    endtask

    initial begin
        {i_rst_n, i_bank_sel, i_carry, i_mem_rdata, i_bit_rdata} = '0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        expect_op = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reg_to_dir();
        t_dir_to_dir();
        t_illegal();
        t_imm();
        t_bit_moves();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
